// >>> design/foaid_io_diag.sv
// foaid_io_diag: keypad output forcing and led diagnosis of the discrete i/o, apb registers
// assumes: pins and keys are asynchronous to ref_clk; servo_enabled and drive_status come
// from drive logic on ref_clk
// assumes: the apb master holds each request until it samples pready high
//
// What this block does
// - hold 5-bit forcing value, 00 to 1F
// - up/down keys step value in forcing display
// - forcing applies only while drive disabled
// - per-output config picks function and polarity
// - input diagnosis lights one segment per input
// - output diagnosis lights one segment per output
// - input diagnosis also enables input forcing
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module foaid_io_diag #(
  parameter int unsigned NUM_DO = foaid_pkg::NUM_DO,
  parameter int unsigned NUM_DI = foaid_pkg::NUM_DI
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [foaid_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // keypad and pins
  input  wire logic                       key_up,
  input  wire logic                       key_down,
  input  wire logic [NUM_DI-1:0]          digital_inputs,
  output logic      [NUM_DO-1:0]          digital_outputs,
  // drive side
  input  wire logic                       servo_enabled,
  input  wire logic [7:0]                 drive_status,
  output logic      [NUM_DI-1:0]          effective_inputs,
  output logic      [7:0]                 led_segments
);

  // ------------------------------------------------------------
  // reset release and input synchronisers
  // ------------------------------------------------------------
  // reset copy, synchroniser stages and key history
  logic              rst_meta;
  logic              rst_n;
  logic [NUM_DI+1:0] pin_meta;
  logic [NUM_DI+1:0] pin_sync;
  logic              up_prev;
  logic              down_prev;

  // reset asserts at once, releases after two edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // keys and input pins through two flops; only pin_sync is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {key_down, key_up, digital_inputs};
      pin_sync <= pin_meta;
    end
  end

  // synchronised pin fields; the keys ride above the inputs
  logic              up_sync;
  logic              down_sync;
  logic [NUM_DI-1:0] di_sync;
  assign di_sync   = pin_sync[NUM_DI-1:0];
  assign up_sync   = pin_sync[NUM_DI];
  assign down_sync = pin_sync[NUM_DI+1];

  // key history for press detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_prev   <= 1'b0;
      down_prev <= 1'b0;
    end else begin
      up_prev   <= up_sync;
      down_prev <= down_sync;
    end
  end

  // a press is a synced rising level; no debounce, so a bouncing key steps twice
  logic up_press;
  logic down_press;
  assign up_press   = up_sync & ~up_prev;
  assign down_press = down_sync & ~down_prev;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // programmable state and address decode
  foaid_pkg::foaid_mode_t     mode;
  foaid_pkg::foaid_do_cfg_t   do_cfg [NUM_DO];
  foaid_pkg::foaid_di_force_t di_force;
  logic [NUM_DO-1:0]          force_value;

  logic access;
  logic wr_en;
  logic hit_mode;
  logic hit_force;
  logic hit_status;
  logic hit_di_force;
  logic [NUM_DO-1:0] hit_cfg;
  logic hit_any;

  // one wait state: pready rises on the second access cycle
  assign access       = psel & penable & ~pready;
  assign wr_en        = access & pwrite;
  assign hit_mode     = (paddr == foaid_pkg::OFS_MODE);
  assign hit_force    = (paddr == foaid_pkg::OFS_FORCE);
  assign hit_status   = (paddr == foaid_pkg::OFS_STATUS);
  assign hit_di_force = (paddr == foaid_pkg::OFS_DI_FORCE);
  assign hit_any      = hit_mode | hit_force | hit_status | hit_di_force | (|hit_cfg);

  // one aligned word per output configuration
  for (genvar i = 0; i < NUM_DO; i++) begin : g_cfg_hit
    localparam logic [foaid_pkg::ADDR_W-1:0] CFG_OFS =
      foaid_pkg::OFS_DO_CFG0 + foaid_pkg::ADDR_W'(i) * foaid_pkg::OFS_DO_STEP;
    assign hit_cfg[i] = (paddr == CFG_OFS);
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------

  // display mode selects what keys and leds mean
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= foaid_pkg::MODE_NORMAL;
    end else if (wr_en && hit_mode) begin
      mode <= foaid_pkg::foaid_mode_t'(pwdata[1:0]);
    end
  end

  // forcing value: keys step it, saturating at the range ends, software may load it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_value <= foaid_pkg::FORCE_RESET;
    end else if (wr_en && hit_force) begin
      force_value <= pwdata[NUM_DO-1:0];
    end else if (mode == foaid_pkg::MODE_OUTPUT_FORCE) begin
      if (up_press && !down_press && force_value != foaid_pkg::FORCE_MAX) begin
        force_value <= force_value + NUM_DO'(1);
      end else if (down_press && !up_press && force_value != foaid_pkg::FORCE_MIN) begin
        force_value <= force_value - NUM_DO'(1);
      end
    end
  end

  // per-output function and polarity settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DO; i++) begin
        do_cfg[i] <= foaid_pkg::DO_CFG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_DO; i++) begin
        if (wr_en && hit_cfg[i]) begin
          do_cfg[i].func <= pwdata[foaid_pkg::FUNC_W-1:0];
          do_cfg[i].inv  <= pwdata[foaid_pkg::CFG_INV_BIT];
        end
      end
    end
  end

  // input forcing mask and levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      di_force <= foaid_pkg::DI_FORCE_RESET;
    end else if (wr_en && hit_di_force) begin
      di_force.mask <= pwdata[NUM_DI-1:0];
      di_force.val  <= pwdata[foaid_pkg::DIF_VAL_LSB +: NUM_DI];
    end
  end

  // ------------------------------------------------------------
  // output and input paths
  // ------------------------------------------------------------
  // forcing qualifiers and the values the pin flops take next
  logic              force_active;
  logic              in_force_active;
  logic [NUM_DO-1:0] next_outputs;
  logic [NUM_DI-1:0] next_inputs;

  // forcing is honoured only with the power stage off, so a slip cannot move the motor
  assign force_active    = (mode == foaid_pkg::MODE_OUTPUT_FORCE) & ~servo_enabled;
  assign in_force_active = (mode == foaid_pkg::MODE_INPUT_DIAG) & ~servo_enabled;

  // forced bit n drives output n, otherwise configured function and polarity
  always_comb begin
    for (int i = 0; i < NUM_DO; i++) begin
      if (force_active) begin
        next_outputs[i] = force_value[i];
      end else begin
        next_outputs[i] = drive_status[do_cfg[i].func] ^ do_cfg[i].inv;
      end
    end
  end

  // masked inputs take the forced level while input diagnosis is entered and the drive is disabled
  assign next_inputs = in_force_active
                     ? ((di_sync & ~di_force.mask) | (di_force.val & di_force.mask))
                     : di_sync;

  // pins leave from flops so no decode glitch reaches the wiring
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      digital_outputs  <= '0;
      effective_inputs <= '0;
    end else begin
      digital_outputs  <= next_outputs;
      effective_inputs <= next_inputs;
    end
  end

  // ------------------------------------------------------------
  // led display
  // ------------------------------------------------------------
  // segment pattern before the display flop
  logic [7:0] next_segments;

  // one lit segment per on signal; shows the forcing value or the registered pin levels
  always_comb begin
    next_segments = '0;
    unique case (mode)
      foaid_pkg::MODE_NORMAL:        next_segments = '0;
      foaid_pkg::MODE_OUTPUT_FORCE:  next_segments[NUM_DO-1:0] = force_value;
      foaid_pkg::MODE_INPUT_DIAG:    next_segments[NUM_DI-1:0] = effective_inputs;
      foaid_pkg::MODE_OUTPUT_STATUS: next_segments[NUM_DO-1:0] = digital_outputs;
    endcase
  end

  // display register; it lags its source by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_segments <= '0;
    end else begin
      led_segments <= next_segments;
    end
  end

  // ------------------------------------------------------------
  // apb read and response
  // ------------------------------------------------------------
  logic [31:0] next_rdata;

  // unmapped offsets read zero and flag an error
  always_comb begin
    next_rdata = foaid_pkg::DATA_ZERO;
    if (hit_mode) begin
      next_rdata[1:0] = mode;
    end
    if (hit_force) begin
      next_rdata[NUM_DO-1:0] = force_value;
    end
    if (hit_status) begin
      next_rdata[foaid_pkg::STAT_DI_LSB +: NUM_DI] = effective_inputs;
      next_rdata[foaid_pkg::STAT_DO_LSB +: NUM_DO] = digital_outputs;
      next_rdata[foaid_pkg::STAT_SRV_BIT]          = servo_enabled;
      next_rdata[foaid_pkg::STAT_FRC_BIT]          = force_active;
    end
    if (hit_di_force) begin
      next_rdata[NUM_DI-1:0]                           = di_force.mask;
      next_rdata[foaid_pkg::DIF_VAL_LSB +: NUM_DI]     = di_force.val;
    end
    for (int i = 0; i < NUM_DO; i++) begin
      if (hit_cfg[i]) begin
        next_rdata[foaid_pkg::FUNC_W-1:0]     = do_cfg[i].func;
        next_rdata[foaid_pkg::CFG_INV_BIT]    = do_cfg[i].inv;
      end
    end
  end

  // answer one cycle after the first access cycle; read data held until the next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= foaid_pkg::DATA_ZERO;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit_any;
      if (access && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

endmodule : foaid_io_diag

// >>> design/foaid_pkg.sv
// foaid_pkg: constants, register map and types for the forced output and i/o diagnosis block
// assumes: a 32-bit apb slave, five digital outputs, eight digital inputs
package foaid_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int unsigned NUM_DO    = 5;
  localparam int unsigned NUM_DI    = 8;
  localparam int unsigned FUNC_W    = 3;
  localparam int unsigned ADDR_W    = 8;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FORCE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DO_CFG0  = 8'h08;  // five words, 0x08..0x18
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_DI_FORCE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DO_STEP  = 8'h04;

  // ------------------------------------------------------------
  // forcing value range and reset values
  // ------------------------------------------------------------
  localparam logic [NUM_DO-1:0] FORCE_MIN    = 5'h00;
  localparam logic [NUM_DO-1:0] FORCE_MAX    = 5'h1F;
  localparam logic [NUM_DO-1:0] FORCE_RESET  = 5'h00;
  localparam logic [31:0]       DATA_ZERO    = 32'h0000_0000;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned STAT_DI_LSB   = 0;
  localparam int unsigned STAT_DO_LSB   = 8;
  localparam int unsigned STAT_SRV_BIT  = 13;
  localparam int unsigned STAT_FRC_BIT  = 14;
  localparam int unsigned DIF_VAL_LSB   = 8;
  localparam int unsigned CFG_INV_BIT   = 8;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_OUTPUT_FORCE,   // output_force_setting shown
    MODE_INPUT_DIAG,     // input_diag_setting shown
    MODE_OUTPUT_STATUS   // output_status_setting shown
  } foaid_mode_t;

  // per-output function configuration
  typedef struct packed {
    logic              inv;
    logic [FUNC_W-1:0] func;
  } foaid_do_cfg_t;

  // input forcing: mask selects forced bits, value gives their level
  typedef struct packed {
    logic [NUM_DI-1:0] val;
    logic [NUM_DI-1:0] mask;
  } foaid_di_force_t;

  localparam foaid_do_cfg_t   DO_CFG_RESET   = '{inv: 1'b0, func: 3'h0};
  localparam foaid_di_force_t DI_FORCE_RESET = '{val: 8'h00, mask: 8'h00};

endpackage : foaid_pkg

// >>> tb/foaid_partner.sv
// foaid_partner: keypad operator and input wiring
// assumes: bench asks for a press by a one-cycle pulse, then waits out busy
`timescale 1ns/100ps
module foaid_partner (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       press_up,
  input  wire logic       press_dn,
  input  wire logic [3:0] hold_len,
  input  wire logic [7:0] pin_val,
  output logic            key_up,
  output logic            key_down,
  output logic      [7:0] digital_inputs,
  output logic            busy
);
  logic [4:0] cnt;
  // pins follow the chosen levels
  assign digital_inputs = pin_val;
  // key held hold_len+1 cycles, then four low cycles; pull-downs read low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {key_up, key_down, busy, cnt} <= '0;
    end else if (!busy) begin
      {key_up, key_down} <= {press_up, press_dn};
      busy <= press_up | press_dn;
      cnt <= {1'b0, hold_len} + 5'h4;
    end else begin
      cnt <= cnt - 5'h1;
      if (cnt == 5'h4) {key_up, key_down} <= 2'b00;
      busy <= (cnt != 5'h0);
    end
  end
endmodule : foaid_partner

// >>> tb/foaid_sva.sv
// foaid_sva: port assertions for the i/o diagnosis block
// assumes: bound to foaid_io_diag; master holds requests until pready
`timescale 1ns/100ps
module foaid_sva #(
  parameter int unsigned NUM_DO = foaid_pkg::NUM_DO,
  parameter int unsigned NUM_DI = foaid_pkg::NUM_DI
) (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              key_up,
  input wire logic              key_down,
  input wire logic [NUM_DI-1:0] digital_inputs,
  input wire logic [NUM_DO-1:0] digital_outputs,
  input wire logic              servo_enabled,
  input wire logic [7:0]        drive_status,
  input wire logic [NUM_DI-1:0] effective_inputs,
  input wire logic [7:0]        led_segments
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // cycles since reset; the inner reset copy lags two flops
  logic [2:0] up_cnt;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  // no bus access and nothing moving on the inputs
  sequence calm_s;
    !psel && $stable({key_up, key_down, servo_enabled, drive_status, digital_inputs});
  endsequence
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_req: assert property (pready |-> psel && penable)
    else $error("ready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  a_out_hold: assert property (calm_s[*6] ##0 up_cnt == 3'h7 |-> $stable(digital_outputs))
    else $error("outputs moved with quiet inputs");
  a_led_hold: assert property (calm_s[*6] ##0 up_cnt == 3'h7 |-> $stable(led_segments))
    else $error("leds moved with quiet inputs");
  a_in_follow: assert property (servo_enabled[*4] ##0 up_cnt == 3'h7 |->
    effective_inputs == $past(digital_inputs, 3)) else $error("inputs forced while enabled");
endmodule : foaid_sva
bind foaid_io_diag foaid_sva #(.NUM_DO(NUM_DO), .NUM_DI(NUM_DI)) i_foaid_sva (
  .ref_clk, .reset_n, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .key_up,
  .key_down, .digital_inputs, .digital_outputs, .servo_enabled, .drive_status,
  .effective_inputs, .led_segments);

// >>> tb/forced_output_and_io_diag_tb.sv
// forced_output_and_io_diag_tb: self-checking bench
// assumes: package, design, checker and partner compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module forced_output_and_io_diag_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n, psel, penable, pwrite, servo_enabled, pready, pslverr;
  logic        key_up, key_down, busy, press_up, press_dn;
  logic [3:0]  hold_len;
  logic [7:0]  paddr, pin_val, drive_status, digital_inputs, effective_inputs, led_segments;
  logic [31:0] pwdata, prdata;
  logic [4:0]  digital_outputs, v;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          compares, error_cnt, cyc;
  always #4 ref_clk = ~ref_clk;
  foaid_io_diag i_foaid_io_diag (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .key_up, .key_down, .digital_inputs,
    .digital_outputs, .servo_enabled, .drive_status, .effective_inputs, .led_segments);
  foaid_partner i_foaid_partner (.ref_clk, .reset_n, .press_up, .press_dn, .hold_len,
    .pin_val, .key_up, .key_down, .digital_inputs, .busy);
  // monitor: each answer meets the oldest note; also the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(pslverr, e[32])
      if (e[33]) `CHK(prdata, e[31:0])
    end
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  // one apb transfer; x = {read, error, data} expected
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    @(posedge ref_clk);
    exp_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0000_0000, {2'b10, d});
  endtask : rd
  // keypad press of random length, waited out
  task automatic key(input logic up);
    @(posedge ref_clk);
    hold_len <= 4'($urandom_range(1, 6));
    press_up <= up;
    press_dn <= !up;
    @(posedge ref_clk);
    press_up <= 1'b0;
    press_dn <= 1'b0;
    wt(2);
    while (busy === 1'b1) @(posedge ref_clk);
    wt(4);
  endtask : key
  task automatic summarize;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, servo_enabled, press_up, press_dn, paddr, pwdata} = '0;
    {drive_status, hold_len, pin_val} = '0;
    void'($urandom(32'hc114));
    wt(5);
    reset_n <= 1'b1;
    wt(3);
    rd(foaid_pkg::OFS_MODE, 32'h0000_0000);
    rd(foaid_pkg::OFS_DO_CFG0, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF, 34'h1_0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000, 34'h3_0000_0000);
    $display("reset test done");
    wr(foaid_pkg::OFS_MODE, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      wr(foaid_pkg::OFS_FORCE, {27'h0, v});
      wt(3);
      `CHK(digital_outputs, v)
      `CHK(led_segments, {3'h0, v})
    end
    rd(foaid_pkg::OFS_STATUS, {17'h0, 2'b10, v, 8'h00});
    $display("forcing test done");
    // key steps saturate at both ends
    wr(foaid_pkg::OFS_FORCE, 32'h0000_001E);
    key(1'b1);
    `CHK(digital_outputs, 5'h1F)
    key(1'b1);
    `CHK(digital_outputs, 5'h1F)
    wr(foaid_pkg::OFS_FORCE, 32'h0000_0001);
    key(1'b0);
    `CHK(digital_outputs, 5'h00)
    key(1'b0);
    rd(foaid_pkg::OFS_FORCE, 32'h0000_0000);
    $display("key test done");
    // drive enabled: forcing ignored, config words pick source and polarity
    wr(foaid_pkg::OFS_FORCE, 32'h0000_001F);
    servo_enabled <= 1'b1;
    for (int i = 0; i < 5; i++)
      wr(foaid_pkg::OFS_DO_CFG0 + 8'(i) * foaid_pkg::OFS_DO_STEP,
         (i == 0) ? 32'h0000_0100 : 32'(i));
    rd(foaid_pkg::OFS_DO_CFG0, 32'h0000_0100);
    for (int i = 0; i < 3; i++) begin
      drive_status <= 8'($urandom);
      wt(4);
      `CHK(digital_outputs, drive_status[4:0] ^ 5'h01)
    end
    servo_enabled <= 1'b0;
    wt(4);
    `CHK(digital_outputs, 5'h1F)
    $display("config test done");
    // input display, then masked input forcing while disabled
    wr(foaid_pkg::OFS_MODE, 32'h0000_0002);
    wr(foaid_pkg::OFS_DI_FORCE, 32'h0000_050F);
    servo_enabled <= 1'b1;
    pin_val <= 8'($urandom);
    wt(6);
    `CHK(led_segments, pin_val)
    servo_enabled <= 1'b0;
    wt(6);
    `CHK(effective_inputs, (pin_val & 8'hF0) | 8'h05)
    `CHK(led_segments, (pin_val & 8'hF0) | 8'h05)
    $display("input test done");
    // output display; keys outside forcing leave the value alone
    wr(foaid_pkg::OFS_MODE, 32'h0000_0003);
    wt(4);
    `CHK(led_segments[4:0], drive_status[4:0] ^ 5'h01)
    key(1'b0);
    rd(foaid_pkg::OFS_FORCE, 32'h0000_001F);
    $display("output test done");
    // normal display: leds dark, outputs keep the configured path
    wr(foaid_pkg::OFS_MODE, 32'h0000_0000);
    wt(4);
    `CHK(led_segments, 8'h00)
    `CHK(digital_outputs, drive_status[4:0] ^ 5'h01)
    $display("normal test done");
    summarize();
  end
endmodule : forced_output_and_io_diag_tb
